// *** common/pmblf_defines.svh ***
// register offsets, status bit positions, reset values and timing counts of the limit bank
`ifndef PMBLF_DEFINES_SVH
`define PMBLF_DEFINES_SVH

`define PMBLF_CMD_CLEAR_FAULTS      8'h03
`define PMBLF_CMD_STORE_DEFAULTS    8'h11
`define PMBLF_CMD_TEMP_WARN         8'h51
`define PMBLF_CMD_IN_OV             8'h55
`define PMBLF_CMD_IN_OC             8'h5B
`define PMBLF_CMD_STATUS_BYTE       8'h78
`define PMBLF_CMD_STATUS_WORD       8'h79
`define PMBLF_CMD_STATUS_INPUT      8'h7C
`define PMBLF_CMD_STATUS_TEMP       8'h7D

`define PMBLF_EXP_MSB               15
`define PMBLF_EXP_LSB               11
`define PMBLF_MANT_MSB              10
`define PMBLF_MANT_LSB              0

`define PMBLF_TEMP_WARN_RST         16'h005F
`define PMBLF_IN_OV_NVM_RST         16'h0011
`define PMBLF_IN_OV_STRAP_RST       16'h000E
`define PMBLF_IN_OC_RST             16'h00FF
`define PMBLF_STORE_OV_BASE         16'h000E

`define PMBLF_SB_OTHER_BIT          0
`define PMBLF_SB_TEMP_BIT           2
`define PMBLF_SW_INPUT_BIT          13
`define PMBLF_ST_OT_WARN_BIT        6
`define PMBLF_SI_IN_OV_BIT          7
`define PMBLF_SI_IN_OC_BIT          1

`define PMBLF_STRAP_SETTLE          2'h3

`endif

// *** common/pmblf_pkg.sv ***
// types shared by the limit bank modules
`default_nettype none
package pmblf_pkg;
	typedef enum logic [0:0] {
		PMBLF_INIT_WAIT,
		PMBLF_INIT_DONE
	} pmblf_init_t;

	typedef logic [15:0] pmblf_word_t;
endpackage : pmblf_pkg
`default_nettype wire

// *** common/pmblf_lim_if.sv ***
// threshold, telemetry and hit flag carried between the bank and one comparator
`timescale 1ns/1ps
`default_nettype none
interface pmblf_lim_if;
	logic [15:0] threshold;
	logic [15:0] telemetry;
	logic        hit;

	modport bank (output threshold, output telemetry, input hit);
	modport cmp  (input threshold, input telemetry, output hit);
endinterface : pmblf_lim_if
`default_nettype wire

// *** src/pmblf_cmp.sv ***
// compares a signed fixed-point telemetry value with a linear-format threshold
`timescale 1ns/1ps
`default_nettype none
`include "pmblf_defines.svh"
module pmblf_cmp import pmblf_pkg::*; #(
	parameter int FRAC_BITS = 0
) (
	// clock and reset
	input  wire logic    sys_clk_i,
	input  wire logic    resetn_i,
	// threshold and telemetry
	pmblf_lim_if.cmp     lim
);
	// refuse fraction widths the 2^16 scaling cannot hold
	if (FRAC_BITS < 0 || FRAC_BITS > 16) begin : g_frac_check
		$error("pmblf_cmp: FRAC_BITS must lie in 0..16");
	end

	logic signed [4:0]  exp_s;
	logic signed [10:0] mant_s;
	logic signed [63:0] thr_scaled;
	logic signed [63:0] tel_scaled;
	logic [5:0]         shift;
	logic               next_hit;
	logic               hit_q;

	// both sides are scaled by 2^16 so a negative exponent keeps its fraction
	always_comb begin
		exp_s      = lim.threshold[`PMBLF_EXP_MSB:`PMBLF_EXP_LSB];
		mant_s     = lim.threshold[`PMBLF_MANT_MSB:`PMBLF_MANT_LSB];
		shift      = 6'(7'(signed'(exp_s)) + 7'sd16);
		thr_scaled = 64'(signed'(mant_s)) <<< shift;
		tel_scaled = 64'(signed'(lim.telemetry)) <<< (16 - FRAC_BITS);
		next_hit   = (tel_scaled >= thr_scaled);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= next_hit;
		end
	end

	assign lim.hit = hit_q;
endmodule : pmblf_cmp
`default_nettype wire

// *** src/pmblf_bank.sv ***
// limit register bank with threshold comparison, sticky status bits and host alert
`timescale 1ns/1ps
`default_nettype none
`include "pmblf_defines.svh"
module pmblf_bank import pmblf_pkg::*; #(
	parameter int TEMP_FRAC = 0,
	parameter int VIN_FRAC  = 0,
	parameter int IIN_FRAC  = 0
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	// configuration strap pin, high selects pinstrap mode
	input  wire logic        strap_mode_i,
	// command port
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic [15:0]      cmd_rdata_o,
	output logic             cmd_rvalid_o,
	output logic             cmd_ack_o,
	// telemetry, signed fixed point
	input  wire logic [15:0] temp_i,
	input  wire logic [15:0] vin_i,
	input  wire logic [15:0] iin_i,
	// status and alert
	output logic [15:0]      status_word_o,
	output logic [7:0]       status_temp_o,
	output logic [7:0]       status_input_o,
	output logic             host_alert_line_n_o
);
	pmblf_lim_if temp_lim ();
	pmblf_lim_if ov_lim ();
	pmblf_lim_if oc_lim ();

	pmblf_cmp #(.FRAC_BITS(TEMP_FRAC)) u_temp_cmp (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.lim       (temp_lim.cmp)
	);
	pmblf_cmp #(.FRAC_BITS(VIN_FRAC)) u_ov_cmp (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.lim       (ov_lim.cmp)
	);
	pmblf_cmp #(.FRAC_BITS(IIN_FRAC)) u_oc_cmp (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.lim       (oc_lim.cmp)
	);

	// strap synchroniser
	logic        strap_meta;
	logic        strap_sync;
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
		end else begin
			strap_meta <= strap_mode_i;
			strap_sync <= strap_meta;
		end
	end

	pmblf_init_t init_state;
	pmblf_init_t next_init_state;
	logic [1:0]  init_cnt;
	logic [1:0]  next_init_cnt;
	pmblf_word_t temp_warn_threshold;
	pmblf_word_t input_overvoltage_threshold;
	pmblf_word_t input_overcurrent_threshold;
	pmblf_word_t next_temp_warn;
	pmblf_word_t next_in_ov;
	pmblf_word_t next_in_oc;
	logic        ot_warn;
	logic        in_ov;
	logic        in_oc;
	logic        next_ot_warn;
	logic        next_in_ov_f;
	logic        next_in_oc_f;
	logic [15:0] next_rdata;
	logic        next_rvalid;
	logic        next_ack;
	logic [15:0] next_sw;
	logic [7:0]  next_st;
	logic [7:0]  next_si;
	logic        next_alert_n;
	logic        wr;
	logic        rd;
	logic        clr;

	assign temp_lim.threshold = temp_warn_threshold;
	assign temp_lim.telemetry = temp_i;
	assign ov_lim.threshold   = input_overvoltage_threshold;
	assign ov_lim.telemetry   = vin_i;
	assign oc_lim.threshold   = input_overcurrent_threshold;
	assign oc_lim.telemetry   = iin_i;

	always_comb begin
		wr  = cmd_valid_i && cmd_write_i;
		rd  = cmd_valid_i && !cmd_write_i;
		clr = wr && (cmd_code_i == `PMBLF_CMD_CLEAR_FAULTS);

		next_init_state = init_state;
		next_init_cnt   = init_cnt;
		next_temp_warn  = temp_warn_threshold;
		next_in_ov      = input_overvoltage_threshold;
		next_in_oc      = input_overcurrent_threshold;

		// strap is read once the synchroniser has settled after release
		unique case (init_state)
			PMBLF_INIT_WAIT: begin
				next_init_cnt = init_cnt + 2'h1;
				if (init_cnt == `PMBLF_STRAP_SETTLE) begin
					next_init_state = PMBLF_INIT_DONE;
					if (strap_sync) begin
						next_in_ov = `PMBLF_IN_OV_STRAP_RST;
					end
				end
			end
			PMBLF_INIT_DONE: begin
				next_init_cnt = init_cnt;
			end
		endcase

		if (wr) begin
			unique case (cmd_code_i)
				`PMBLF_CMD_TEMP_WARN: next_temp_warn = cmd_wdata_i;
				`PMBLF_CMD_IN_OV:     next_in_ov = cmd_wdata_i;
				`PMBLF_CMD_IN_OC:     next_in_oc = cmd_wdata_i;
				`PMBLF_CMD_STORE_DEFAULTS: begin
					next_in_ov = `PMBLF_STORE_OV_BASE
						+ {14'h0000, input_overvoltage_threshold[1:0]};
				end
				default: begin
				end
			endcase
		end

		// a trip in the clearing cycle survives the clear
		next_ot_warn = temp_lim.hit || (ot_warn && !clr);
		next_in_ov_f = ov_lim.hit || (in_ov && !clr);
		next_in_oc_f = oc_lim.hit || (in_oc && !clr);

		next_sw = 16'h0000;
		next_sw[`PMBLF_SB_TEMP_BIT]  = next_ot_warn;
		next_sw[`PMBLF_SB_OTHER_BIT] = next_in_ov_f || next_in_oc_f;
		next_sw[`PMBLF_SW_INPUT_BIT] = next_in_ov_f || next_in_oc_f;
		next_st = 8'h00;
		next_st[`PMBLF_ST_OT_WARN_BIT] = next_ot_warn;
		next_si = 8'h00;
		next_si[`PMBLF_SI_IN_OV_BIT] = next_in_ov_f;
		next_si[`PMBLF_SI_IN_OC_BIT] = next_in_oc_f;
		next_alert_n = !(next_ot_warn || next_in_ov_f || next_in_oc_f);

		next_rdata  = 16'h0000;
		next_rvalid = rd;
		next_ack    = wr;
		if (rd) begin
			unique case (cmd_code_i)
				`PMBLF_CMD_TEMP_WARN:    next_rdata = temp_warn_threshold;
				`PMBLF_CMD_IN_OV:        next_rdata = input_overvoltage_threshold;
				`PMBLF_CMD_IN_OC:        next_rdata = input_overcurrent_threshold;
				`PMBLF_CMD_STATUS_BYTE:  next_rdata = {8'h00, status_word_o[7:0]};
				`PMBLF_CMD_STATUS_WORD:  next_rdata = status_word_o;
				`PMBLF_CMD_STATUS_INPUT: next_rdata = {8'h00, status_input_o};
				`PMBLF_CMD_STATUS_TEMP:  next_rdata = {8'h00, status_temp_o};
				default:                 next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			init_state                  <= PMBLF_INIT_WAIT;
			init_cnt                    <= 2'h0;
			temp_warn_threshold         <= `PMBLF_TEMP_WARN_RST;
			input_overvoltage_threshold <= `PMBLF_IN_OV_NVM_RST;
			input_overcurrent_threshold <= `PMBLF_IN_OC_RST;
			ot_warn                     <= 1'b0;
			in_ov                       <= 1'b0;
			in_oc                       <= 1'b0;
			status_word_o               <= 16'h0000;
			status_temp_o               <= 8'h00;
			status_input_o              <= 8'h00;
			host_alert_line_n_o         <= 1'b1;
			cmd_rdata_o                 <= 16'h0000;
			cmd_rvalid_o                <= 1'b0;
			cmd_ack_o                   <= 1'b0;
		end else begin
			init_state                  <= next_init_state;
			init_cnt                    <= next_init_cnt;
			temp_warn_threshold         <= next_temp_warn;
			input_overvoltage_threshold <= next_in_ov;
			input_overcurrent_threshold <= next_in_oc;
			ot_warn                     <= next_ot_warn;
			in_ov                       <= next_in_ov_f;
			in_oc                       <= next_in_oc_f;
			status_word_o               <= next_sw;
			status_temp_o               <= next_st;
			status_input_o              <= next_si;
			host_alert_line_n_o         <= next_alert_n;
			cmd_rdata_o                 <= next_rdata;
			cmd_rvalid_o                <= next_rvalid;
			cmd_ack_o                   <= next_ack;
		end
	end
endmodule : pmblf_bank
`default_nettype wire

// *** src/pmblf_bank_unused_check_removed.sv ***
// holds no logic; the limit bank lives in the bank and comparator sources
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** bench/pmblf_bank_sva.sv ***
// concurrent checks on the limit bank ports
`timescale 1ns/1ps
`default_nettype none
module pmblf_bank_sva (
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	// command port
	input wire logic        cmd_valid_i,
	input wire logic        cmd_write_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic        cmd_rvalid_o,
	input wire logic        cmd_ack_o,
	// status and alert
	input wire logic [15:0] status_word_o,
	input wire logic [7:0]  status_temp_o,
	input wire logic [7:0]  status_input_o,
	input wire logic        host_alert_line_n_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rd(logic [7:0] c); cmd_valid_i && !cmd_write_i && cmd_code_i == c; endsequence
	sequence s_wr(logic [7:0] c); cmd_valid_i && cmd_write_i && cmd_code_i == c; endsequence
	property p_rd; cmd_valid_i && !cmd_write_i |=> cmd_rvalid_o && !cmd_ack_o; endproperty
	property p_wr; cmd_valid_i && cmd_write_i |=> cmd_ack_o && cmd_rdata_o == 16'h0000; endproperty
	property p_temp; status_temp_o[6] |-> status_word_o[2] && !host_alert_line_n_o; endproperty
	property p_ov;
		status_input_o[7] |-> status_word_o[0] && status_word_o[13] && !host_alert_line_n_o;
	endproperty
	property p_oc;
		status_input_o[1] |-> status_word_o[0] && status_word_o[13] && !host_alert_line_n_o;
	endproperty
	property p_alert;
		host_alert_line_n_o == !(status_temp_o[6] || status_input_o[7] || status_input_o[1]);
	endproperty
	property p_sticky;
		status_temp_o[6] && !(cmd_valid_i && cmd_write_i && cmd_code_i == 8'h03) |=> status_temp_o[6];
	endproperty
	property p_store;
		s_wr(8'h11) ##[1:2] s_rd(8'h55) |=> cmd_rdata_o >= 16'h000E && cmd_rdata_o <= 16'h0011;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered next cycle");
	a_wr: assert property (p_wr) else $error("write not acked next cycle");
	a_temp: assert property (p_temp) else $error("temperature summary missing");
	a_ov: assert property (p_ov) else $error("overvoltage summary missing");
	a_oc: assert property (p_oc) else $error("overcurrent summary missing");
	a_alert: assert property (p_alert) else $error("alert disagrees with flags");
	a_sticky: assert property (p_sticky) else $error("warning dropped without clear");
	a_store: assert property (p_store) else $error("stored threshold out of range");
endmodule : pmblf_bank_sva
bind pmblf_bank pmblf_bank_sva pmblf_bank_sva_i (.sys_clk_i, .resetn_i, .cmd_valid_i,
	.cmd_write_i, .cmd_code_i, .cmd_rdata_o, .cmd_rvalid_o, .cmd_ack_o, .status_word_o,
	.status_temp_o, .status_input_o, .host_alert_line_n_o);
`default_nettype wire

// *** bench/pmblf_host.sv ***
// host model issuing one command per call on the command port
`timescale 1ns/1ps
`default_nettype none
module pmblf_host (
	// clock
	input  wire logic        sys_clk_i,
	// command port
	output logic             cmd_valid_o,
	output logic             cmd_write_o,
	output logic [7:0]       cmd_code_o,
	output logic [15:0]      cmd_wdata_o,
	input  wire logic [15:0] cmd_rdata_i,
	input  wire logic        cmd_rvalid_i,
	input  wire logic        cmd_ack_i
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o  = 8'h00;
		cmd_wdata_o = 16'h0000;
	end
	// whole 16-bit words; idle lines carry inverted junk
	task xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [16:0] r);
		@(negedge sys_clk_i);
		cmd_valid_o = 1'b1;
		cmd_write_o = w;
		cmd_code_o  = c;
		cmd_wdata_o = d;
		@(negedge sys_clk_i);
		r = {(w ? cmd_ack_i : cmd_rvalid_i), cmd_rdata_i};
		cmd_valid_o = 1'b0;
		cmd_code_o  = ~c;
		cmd_wdata_o = ~d;
	endtask : xfer
endmodule : pmblf_host
`default_nettype wire

// *** bench/pmblf_bank_tb.sv ***
// self-checking bench for the limit bank
`timescale 1ns/1ps
`default_nettype none
`include "pmblf_defines.svh"
module pmblf_bank_tb import pmblf_pkg::*;;
	logic        sys_clk_i, resetn_i, strap_mode_i, cmd_valid_i, cmd_write_i;
	logic        cmd_rvalid_o, cmd_ack_o, host_alert_line_n_o;
	logic [7:0]  cmd_code_i, status_temp_o, status_input_o;
	pmblf_word_t cmd_wdata_i, cmd_rdata_o, temp_i, vin_i, iin_i, status_word_o;
	logic [16:0] got;
	int          num_errors, samples_checked;
	pmblf_bank pmblf_bank_i (.sys_clk_i, .resetn_i, .strap_mode_i, .cmd_valid_i, .cmd_write_i,
		.cmd_code_i, .cmd_wdata_i, .cmd_rdata_o, .cmd_rvalid_o, .cmd_ack_o, .temp_i, .vin_i,
		.iin_i, .status_word_o, .status_temp_o, .status_input_o, .host_alert_line_n_o);
	pmblf_host pmblf_host_i (.sys_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
		.cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i), .cmd_rdata_i(cmd_rdata_o),
		.cmd_rvalid_i(cmd_rvalid_o), .cmd_ack_i(cmd_ack_o));
	task chk(input logic [16:0] exp, input logic [16:0] act);
		samples_checked++;
		if (act !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, act, exp);
		end
	endtask : chk
	task rd(input logic [7:0] c, input logic [15:0] e);
		pmblf_host_i.xfer(1'b0, c, 16'h0000, got);
		chk({1'b1, e}, got);
	endtask : rd
	task wr(input logic [7:0] c, input logic [15:0] d);
		pmblf_host_i.xfer(1'b1, c, d, got);
		chk({1'b1, 16'h0000}, got);
	endtask : wr
	// telemetry reaches the status outputs two edges after it is taken
	task tele(input logic [15:0] t, input logic [15:0] v, input logic [15:0] i);
		@(negedge sys_clk_i);
		temp_i = t;
		vin_i  = v;
		iin_i  = i;
		repeat (3) @(negedge sys_clk_i);
	endtask : tele
	task stat(input logic [16:0] e, input logic [15:0] sw);
		chk(e, {host_alert_line_n_o, status_temp_o, status_input_o});
		chk({1'b0, sw}, {1'b0, status_word_o});
	endtask : stat
	task end_of_test;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		num_errors++;
		end_of_test();
	end
	initial begin
		{resetn_i, strap_mode_i, temp_i, vin_i, iin_i} = '0;
		repeat (10) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		rd(`PMBLF_CMD_TEMP_WARN, 16'h005F);
		rd(`PMBLF_CMD_IN_OV, 16'h0011);
		rd(`PMBLF_CMD_IN_OC, 16'h00FF);
		rd(8'h20, 16'h0000);
		wr(`PMBLF_CMD_IN_OC, 16'h0805);
		rd(`PMBLF_CMD_IN_OC, 16'h0805);
		tele(16'h0000, 16'h0000, 16'd9);
		stat({1'b1, 16'h0000}, 16'h0000);
		tele(16'h0000, 16'h0000, 16'd10);
		stat({1'b0, 8'h00, 8'h02}, 16'h2001);
		tele(16'd94, 16'h0000, 16'h0000);
		stat({1'b0, 8'h00, 8'h02}, 16'h2001);
		rd(`PMBLF_CMD_STATUS_INPUT, 16'h0002);
		wr(`PMBLF_CMD_CLEAR_FAULTS, 16'h0000);
		stat({1'b1, 16'h0000}, 16'h0000);
		tele(16'd95, 16'h0000, 16'h0000);
		stat({1'b0, 8'h40, 8'h00}, 16'h0004);
		rd(`PMBLF_CMD_STATUS_TEMP, 16'h0040);
		rd(`PMBLF_CMD_STATUS_BYTE, 16'h0004);
		tele(16'h0000, 16'd17, 16'h0000);
		wr(`PMBLF_CMD_CLEAR_FAULTS, 16'h0000);
		stat({1'b0, 8'h00, 8'h80}, 16'h2001);
		rd(`PMBLF_CMD_STATUS_WORD, 16'h2001);
		tele(16'h0000, 16'h0000, 16'h0000);
		wr(`PMBLF_CMD_CLEAR_FAULTS, 16'h0000);
		stat({1'b1, 16'h0000}, 16'h0000);
		// negative exponent: 190 * 2^-1 is 95 degrees
		wr(`PMBLF_CMD_TEMP_WARN, 16'hF8BE);
		rd(`PMBLF_CMD_TEMP_WARN, 16'hF8BE);
		tele(16'd94, 16'h0000, 16'h0000);
		stat({1'b1, 16'h0000}, 16'h0000);
		tele(16'd95, 16'h0000, 16'h0000);
		stat({1'b0, 8'h40, 8'h00}, 16'h0004);
		tele(16'h0000, 16'h0000, 16'h0000);
		wr(`PMBLF_CMD_CLEAR_FAULTS, 16'h0000);
		stat({1'b1, 16'h0000}, 16'h0000);
		for (int b = 0; b < 4; b++) begin
			wr(`PMBLF_CMD_IN_OV, 16'h0020 | 16'(b));
			wr(`PMBLF_CMD_STORE_DEFAULTS, 16'h0000);
			rd(`PMBLF_CMD_IN_OV, 16'h000E + 16'(b));
		end
		@(negedge sys_clk_i);
		resetn_i = 1'b0;
		strap_mode_i = 1'b1;
		repeat (10) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		repeat (6) @(negedge sys_clk_i);
		rd(`PMBLF_CMD_IN_OV, 16'h000E);
		end_of_test();
	end
endmodule : pmblf_bank_tb
`default_nettype wire
